// ### design/acc_move_round.sv
// Formats an accumulator for a move to a general-purpose register.
`timescale 1ns/1ps
module acc_move_round (
  input wire logic [47:0] acc_i,
  input wire logic frac_i,
  input wire logic sign_sel_i,
  input wire logic round_sel_i,
  output logic [31:0] data_o
);
  logic inc32;
  logic inc16;
  logic [31:0] r32;
  logic [15:0] r16;

  always_comb begin
    inc32 = round_sel_i && ((acc_i[7:0] > mac_status_pkg::ROUND_HALF8) ||
      ((acc_i[7:0] == mac_status_pkg::ROUND_HALF8) && acc_i[8]));
    inc16 = (acc_i[23:0] > mac_status_pkg::ROUND_HALF24) ||
      ((acc_i[23:0] == mac_status_pkg::ROUND_HALF24) && acc_i[24]);
    r32 = acc_i[39:8] + {31'h0000_0000, inc32};
    r16 = acc_i[39:24] + {15'h0000, inc16};
    if (!frac_i) begin
      data_o = acc_i[31:0];
    end else if (!sign_sel_i) begin
      data_o = r32;
    end else begin
      data_o = {16'h0000, r16};
    end
  end
endmodule : acc_move_round

// ### design/acc_slot.sv
// One accumulator with its sticky overflow flag and saturation hold.
`timescale 1ns/1ps
module acc_slot #(
  parameter logic [1:0] IDX = 2'd0
) (
  input wire logic clk_i,
  input wire logic reset_i,
  mac_cmd_if.slot cmd,
  output logic [47:0] acc_o,
  output logic pav_o,
  output logic pav_next_o
);
  typedef struct packed {
    logic [47:0] acc;
    logic pav;
    logic sat;
  } slot_state_t;

  slot_state_t s_q;
  slot_state_t s_d;
  logic hit;
  logic ovf;
  logic [48:0] sum;
  logic [47:0] limit;

  always_comb begin
    hit = cmd.valid && (cmd.dst == IDX) && !s_q.sat;
    sum = cmd.sub ? ({1'b0, s_q.acc} - {1'b0, cmd.prod}) : ({1'b0, s_q.acc} + {1'b0, cmd.prod});
    if (cmd.unsigned_int) begin
      ovf = cmd.prod_ovf || sum[48];
      limit = cmd.sub ? mac_status_pkg::UINT_MIN : mac_status_pkg::UINT_MAX;
    end else begin
      ovf = cmd.prod_ovf || ((s_q.acc[47] == (cmd.prod[47] ^ cmd.sub)) &&
        (sum[47] != s_q.acc[47]));
      if (cmd.prod_neg ^ cmd.sub) begin
        limit = cmd.frac ? mac_status_pkg::FRAC_MIN : mac_status_pkg::SINT_MIN;
      end else begin
        limit = cmd.frac ? mac_status_pkg::FRAC_MAX : mac_status_pkg::SINT_MAX;
      end
    end
    s_d = s_q;
    if (cmd.clear || (cmd.load && cmd.load_idx == IDX)) begin
      s_d.pav = 1'b0;
      s_d.sat = 1'b0;
    end
    if (hit) begin
      s_d.acc = (ovf && cmd.sat_en) ? limit : sum[47:0];
      if (ovf) begin
        s_d.pav = 1'b1;
        s_d.sat = cmd.sat_en;
      end
    end
    if (cmd.load && cmd.load_idx == IDX) begin
      s_d.acc = cmd.load_data;
    end
    if (reset_i) begin
      s_d.acc = mac_status_pkg::ACC_RESET;
      s_d.pav = 1'b0;
      s_d.sat = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  assign acc_o = s_q.acc;
  assign pav_o = s_q.pav;
  assign pav_next_o = s_d.pav;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  property p_sat_hold;
    @(posedge clk_i) disable iff (reset_i)
    (s_q.sat && !cmd.clear && !(cmd.load && cmd.load_idx == IDX)) |=> $stable(s_q.acc);
  endproperty
  a_sat_hold: assert property (p_sat_hold) else $error("saturated accumulator changed");

  property p_sat_limit;
    @(posedge clk_i) disable iff (reset_i)
    (hit && ovf && cmd.sat_en && !(cmd.load && cmd.load_idx == IDX)) |=>
      (s_q.acc == $past(limit)) && s_q.sat;
  endproperty
  a_sat_limit: assert property (p_sat_limit) else $error("overflow did not saturate");

  property p_pav_set;
    @(posedge clk_i) disable iff (reset_i)
    (hit && ovf) |=> s_q.pav;
  endproperty
  a_pav_set: assert property (p_pav_set) else $error("overflow flag not set");

  property p_no_sat_when_off;
    @(posedge clk_i) disable iff (reset_i)
    (hit && !cmd.sat_en && !(cmd.load && cmd.load_idx == IDX)) |=>
      (s_q.acc == $past(sum[47:0])) && !s_q.sat;
  endproperty
  a_no_sat_when_off: assert property (p_no_sat_when_off)
    else $error("saturated while off");

  property p_unsigned_limit;
    @(posedge clk_i) disable iff (reset_i)
    (hit && ovf && cmd.sat_en && cmd.unsigned_int &&
      !(cmd.load && cmd.load_idx == IDX)) |=>
      (s_q.acc == ($past(cmd.sub) ? mac_status_pkg::UINT_MIN : mac_status_pkg::UINT_MAX));
  endproperty
  a_unsigned_limit: assert property (p_unsigned_limit)
    else $error("unsigned saturation limit wrong");
endmodule : acc_slot

// ### design/mac_cmd_if.sv
// Command bundle broadcast from the control logic to the accumulator slots.
`timescale 1ns/1ps
interface mac_cmd_if;
  logic valid;
  logic sub;
  logic [1:0] dst;
  logic [47:0] prod;
  logic prod_ovf;
  logic prod_neg;
  logic sat_en;
  logic unsigned_int;
  logic frac;
  logic clear;
  logic load;
  logic [1:0] load_idx;
  logic [47:0] load_data;
  modport drive (output valid, sub, dst, prod, prod_ovf, prod_neg, sat_en, unsigned_int,
    frac, clear, load, load_idx, load_data);
  modport slot (input valid, sub, dst, prod, prod_ovf, prod_neg, sat_en, unsigned_int,
    frac, clear, load, load_idx, load_data);
endinterface : mac_cmd_if

// ### design/mac_mode_status.sv
// Mode, overflow and rounding control around the four accumulators.
`timescale 1ns/1ps
module mac_mode_status #(
  parameter int NUM_ACC = mac_status_pkg::NUM_ACC
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic op_valid_i,
  input wire logic op_sub_i,
  input wire logic op_word_i,
  input wire logic [1:0] op_acc_i,
  input wire logic [31:0] op_a_i,
  input wire logic [31:0] op_b_i,
  input wire logic status_wr_i,
  input wire logic [31:0] status_wdata_i,
  input wire logic acc_load_i,
  input wire logic [1:0] acc_load_idx_i,
  input wire logic [47:0] acc_load_data_i,
  input wire logic move_i,
  input wire logic [1:0] move_idx_i,
  output logic [31:0] status_rdata_o,
  output logic [31:0] move_data_o,
  output logic move_valid_o
);
  // ------------------------------------------------------------------
  // Parameter check
  // ------------------------------------------------------------------
  if (NUM_ACC != 4) begin : g_bad_num_acc
    $error("NUM_ACC must be 4 to match the two-bit accumulator select");
  end

  typedef struct packed {
    logic [3:0] mode;
    logic ovf;
    logic [31:0] rdata;
    logic [31:0] mdata;
    logic mvalid;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;
  mac_cmd_if cmd ();

  logic sat_en;
  logic sign_sel;
  logic frac_sel;
  logic round_sel;
  logic [31:0] a_ext;
  logic [31:0] b_ext;
  logic sx_a;
  logic sx_b;
  logic signed [65:0] prod_full;
  logic [39:0] frac_upper;
  logic [23:0] frac_low;
  logic frac_inc;
  logic [39:0] prod40;
  logic prod_ovf;
  logic [47:0] acc [NUM_ACC];
  logic [NUM_ACC-1:0] pav;
  logic [NUM_ACC-1:0] pav_next;
  logic [31:0] move_fmt;

  // ------------------------------------------------------------------
  // Product formation
  // ------------------------------------------------------------------
  always_comb begin
    sat_en = s_q.mode[3];
    sign_sel = s_q.mode[2];
    frac_sel = s_q.mode[1];
    round_sel = s_q.mode[0];
    // Word fractions sit in the upper half so both sizes share one binary point.
    if (!op_word_i) begin
      a_ext = op_a_i;
      b_ext = op_b_i;
    end else if (frac_sel) begin
      a_ext = {op_a_i[15:0], 16'h0000};
      b_ext = {op_b_i[15:0], 16'h0000};
    end else if (sign_sel) begin
      a_ext = {16'h0000, op_a_i[15:0]};
      b_ext = {16'h0000, op_b_i[15:0]};
    end else begin
      a_ext = {{16{op_a_i[15]}}, op_a_i[15:0]};
      b_ext = {{16{op_b_i[15]}}, op_b_i[15:0]};
    end
    sx_a = (sign_sel && !frac_sel) ? 1'b0 : a_ext[31];
    sx_b = (sign_sel && !frac_sel) ? 1'b0 : b_ext[31];
    prod_full = $signed({sx_a, a_ext}) * $signed({sx_b, b_ext});
    frac_upper = prod_full[62:23];
    frac_low = {prod_full[22:0], 1'b0};
    frac_inc = round_sel && op_sub_i && ((frac_low > mac_status_pkg::ROUND_HALF24) ||
      ((frac_low == mac_status_pkg::ROUND_HALF24) && frac_upper[0]));
    if (frac_sel) begin
      prod40 = frac_upper + {39'h0, frac_inc};
      prod_ovf = (prod_full[65:62] != {4{prod_full[65]}});
    end else if (sign_sel) begin
      prod40 = prod_full[39:0];
      prod_ovf = (prod_full[65:40] != 26'h000_0000);
    end else begin
      prod40 = prod_full[39:0];
      prod_ovf = (prod_full[65:39] != {27{prod_full[65]}});
    end
  end

  // ------------------------------------------------------------------
  // Command broadcast and accumulators
  // ------------------------------------------------------------------
  assign cmd.valid = op_valid_i;
  assign cmd.sub = op_sub_i;
  assign cmd.dst = op_acc_i;
  assign cmd.prod = {{8{prod40[39] & ~(sign_sel & ~frac_sel)}}, prod40};
  assign cmd.prod_ovf = prod_ovf;
  assign cmd.prod_neg = prod_full[65];
  assign cmd.sat_en = sat_en;
  assign cmd.unsigned_int = sign_sel && !frac_sel;
  assign cmd.frac = frac_sel;
  assign cmd.clear = status_wr_i && !status_wdata_i[mac_status_pkg::POS_OVF];
  assign cmd.load = acc_load_i;
  assign cmd.load_idx = acc_load_idx_i;
  assign cmd.load_data = acc_load_data_i;

  for (genvar i = 0; i < NUM_ACC; i++) begin : g_slot
    acc_slot #(
      .IDX(2'(i))
    ) u_slot (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .cmd(cmd),
      .acc_o(acc[i]),
      .pav_o(pav[i]),
      .pav_next_o(pav_next[i])
    );
  end

  acc_move_round u_move (
    .acc_i(acc[move_idx_i]),
    .frac_i(frac_sel),
    .sign_sel_i(sign_sel),
    .round_sel_i(round_sel),
    .data_o(move_fmt)
  );

  // ------------------------------------------------------------------
  // Status and move registers
  // ------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (status_wr_i) begin
      s_d.mode = status_wdata_i[mac_status_pkg::POS_SAT_EN:mac_status_pkg::POS_ROUND_SEL];
      s_d.ovf = status_wdata_i[mac_status_pkg::POS_OVF];
    end
    // An operation in the same cycle as a status write decides the overflow bit.
    if (op_valid_i) begin
      s_d.ovf = pav_next[op_acc_i];
    end
    s_d.rdata = 32'h0000_0000;
    s_d.rdata[mac_status_pkg::POS_PAV_LO +: 4] = pav_next;
    s_d.rdata[mac_status_pkg::POS_SAT_EN:mac_status_pkg::POS_ROUND_SEL] = s_d.mode;
    s_d.rdata[mac_status_pkg::POS_OVF] = s_d.ovf;
    s_d.mvalid = move_i;
    if (move_i) begin
      s_d.mdata = move_fmt;
    end
    if (reset_i) begin
      s_d.mode = mac_status_pkg::MODE_RESET;
      s_d.ovf = 1'b0;
      s_d.rdata = 32'h0000_0000;
      s_d.mdata = 32'h0000_0000;
      s_d.mvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  assign status_rdata_o = s_q.rdata;
  assign move_data_o = s_q.mdata;
  assign move_valid_o = s_q.mvalid;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  property p_ovf_follows_pav;
    @(posedge clk_i) disable iff (reset_i)
    op_valid_i |=> (status_rdata_o[mac_status_pkg::POS_OVF] == pav[$past(op_acc_i)]);
  endproperty
  a_ovf_follows_pav: assert property (p_ovf_follows_pav)
    else $error("overflow bit mismatch");

  property p_reserved_zero;
    @(posedge clk_i) disable iff (reset_i)
    1'b1 |=> ((status_rdata_o & ~mac_status_pkg::STATUS_RD_MASK) == 32'h0000_0000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits nonzero");

  property p_pav_sticky;
    @(posedge clk_i) disable iff (reset_i)
    (pav[0] && !cmd.clear && !(acc_load_i && acc_load_idx_i == 2'd0)) |=>
      pav[0] && status_rdata_o[mac_status_pkg::POS_PAV_LO];
  endproperty
  a_pav_sticky: assert property (p_pav_sticky) else $error("flag dropped while sticky");

  property p_mode_write;
    @(posedge clk_i) disable iff (reset_i)
    status_wr_i |=> (s_q.mode == $past(status_wdata_i[7:4])) &&
      (status_rdata_o[7:4] == $past(status_wdata_i[7:4]));
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode bits not written");

  property p_ovf_only_from_pav;
    @(posedge clk_i) disable iff (reset_i)
    (op_valid_i && !pav_next[op_acc_i]) |=> !status_rdata_o[mac_status_pkg::POS_OVF];
  endproperty
  a_ovf_only_from_pav: assert property (p_ovf_only_from_pav)
    else $error("spurious overflow");

  property p_move_16bit;
    @(posedge clk_i) disable iff (reset_i)
    (move_i && frac_sel && sign_sel) |=> move_valid_o && (move_data_o[31:16] == 16'h0000);
  endproperty
  a_move_16bit: assert property (p_move_16bit) else $error("16-bit move upper word set");

  property p_move_plain32;
    @(posedge clk_i) disable iff (reset_i)
    (move_i && frac_sel && !sign_sel && !round_sel) |=>
      (move_data_o == $past(acc[move_idx_i][39:8]));
  endproperty
  a_move_plain32: assert property (p_move_plain32) else $error("32-bit move altered");

  property p_move_keeps_acc;
    @(posedge clk_i) disable iff (reset_i)
    (move_i && !op_valid_i && !acc_load_i) |=> (acc[$past(move_idx_i)] ==
      $past(acc[move_idx_i]));
  endproperty
  a_move_keeps_acc: assert property (p_move_keeps_acc) else $error("move changed acc");

  // ------------------------------------------------------------------
  // Flag and overflow checks
  // ------------------------------------------------------------------
  // A clear on its own empties all four flags; an op in the same cycle may set one again.
  property p_clear_drops_flags;
    @(posedge clk_i) disable iff (reset_i)
    (cmd.clear && !op_valid_i) |=>
      (status_rdata_o[mac_status_pkg::POS_PAV_LO +: 4] == 4'h0);
  endproperty
  a_clear_drops_flags: assert property (p_clear_drops_flags)
    else $error("flags survived a clear");

  property p_load_clears_flag;
    @(posedge clk_i) disable iff (reset_i)
    (acc_load_i && !(op_valid_i && op_acc_i == acc_load_idx_i)) |=>
      !pav[$past(acc_load_idx_i)];
  endproperty
  a_load_clears_flag: assert property (p_load_clears_flag)
    else $error("flag survived a load");

  property p_write_sets_ovf;
    @(posedge clk_i) disable iff (reset_i)
    (status_wr_i && !op_valid_i) |=>
      (status_rdata_o[mac_status_pkg::POS_OVF] ==
        $past(status_wdata_i[mac_status_pkg::POS_OVF]));
  endproperty
  a_write_sets_ovf: assert property (p_write_sets_ovf)
    else $error("overflow bit not written");

  // A saturated destination keeps its flag, so a product overflow shows unless a clear or a load comes in the same cycle.
  property p_prod_ovf_flag;
    @(posedge clk_i) disable iff (reset_i)
    (op_valid_i && prod_ovf && !cmd.clear && !acc_load_i) |=>
      status_rdata_o[mac_status_pkg::POS_OVF];
  endproperty
  a_prod_ovf_flag: assert property (p_prod_ovf_flag)
    else $error("product overflow not flagged");

  // ------------------------------------------------------------------
  // Move format checks
  // ------------------------------------------------------------------
  property p_move_int;
    @(posedge clk_i) disable iff (reset_i)
    (move_i && !frac_sel) |=>
      move_valid_o && (move_data_o == $past(acc[move_idx_i][31:0]));
  endproperty
  a_move_int: assert property (p_move_int)
    else $error("integer move altered");

  // The 16-bit result may differ from the truncated word only by the rounding increment.
  property p_move_round16;
    @(posedge clk_i) disable iff (reset_i)
    (move_i && frac_sel && sign_sel) |=>
      ((move_data_o[15:0] == $past(acc[move_idx_i][39:24])) ||
      (move_data_o[15:0] == $past(acc[move_idx_i][39:24]) + 16'h0001));
  endproperty
  a_move_round16: assert property (p_move_round16)
    else $error("16-bit move not taken from upper bits");
endmodule : mac_mode_status

// ### design/mac_status_pkg.sv
// Constants shared by the multiply-accumulate mode and status logic.
package mac_status_pkg;
  // --------------------------------------------------------------------
  // Status register layout
  // --------------------------------------------------------------------
  localparam int STATUS_W = 32;
  localparam int POS_PAV_LO = 8;
  localparam int POS_SAT_EN = 7;
  localparam int POS_SIGN_SEL = 6;
  localparam int POS_FRAC_SEL = 5;
  localparam int POS_ROUND_SEL = 4;
  localparam int POS_OVF = 1;
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [3:0] PAV_RESET = 4'h0;
  localparam logic [31:0] STATUS_RD_MASK = 32'h0000_0ff2;
  // --------------------------------------------------------------------
  // Datapath widths and saturation limits
  // --------------------------------------------------------------------
  localparam int ACC_W = 48;
  localparam int PROD_W = 40;
  localparam int NUM_ACC = 4;
  localparam logic [47:0] ACC_RESET = 48'h0000_0000_0000;
  localparam logic [47:0] SINT_MAX = 48'h0000_7fff_ffff;
  localparam logic [47:0] SINT_MIN = 48'hffff_8000_0000;
  localparam logic [47:0] UINT_MAX = 48'h0000_ffff_ffff;
  localparam logic [47:0] UINT_MIN = 48'h0000_0000_0000;
  localparam logic [47:0] FRAC_MAX = 48'h007f_ffff_ffff;
  localparam logic [47:0] FRAC_MIN = 48'hff80_0000_0000;
  localparam logic [23:0] ROUND_HALF24 = 24'h80_0000;
  localparam logic [7:0] ROUND_HALF8 = 8'h80;
endpackage : mac_status_pkg

// ### verification/mac_issue_model.sv
// Instruction pipeline model that issues accumulate and subtract operations.
`timescale 1ns/1ps
module mac_issue_model (
  input wire logic clk_i,
  output logic op_valid_o,
  output logic op_sub_o,
  output logic op_word_o,
  output logic [1:0] op_acc_o,
  output logic [31:0] op_a_o,
  output logic [31:0] op_b_o
);
  initial begin
    op_valid_o = 1'b0;
    op_sub_o = 1'b0;
    op_word_o = 1'b0;
    op_acc_o = 2'h0;
    op_a_o = 32'h0;
    op_b_o = 32'h0;
  end

  // Operands are inverted once the issue cycle ends, so a late sample sees wrong data.
  task automatic issue(input logic sub, input logic word, input logic [1:0] acc,
      input logic [31:0] a, input logic [31:0] b);
    @(posedge clk_i);
    op_valid_o <= 1'b1;
    op_sub_o <= sub;
    op_word_o <= word;
    op_acc_o <= acc;
    op_a_o <= a;
    op_b_o <= b;
    @(posedge clk_i);
    op_valid_o <= 1'b0;
    op_sub_o <= ~sub;
    op_a_o <= ~a;
    op_b_o <= ~b;
    #1;
  endtask : issue
endmodule : mac_issue_model

// ### verification/tb_top.sv
// Self-checking bench for the multiply-accumulate mode and status block.
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic op_valid, op_sub, op_word;
  logic [1:0] op_acc;
  logic [31:0] op_a, op_b;
  logic st_wr = 1'b0;
  logic [31:0] st_wdata = 32'h0;
  logic ld = 1'b0;
  logic [1:0] ld_idx = 2'h0;
  logic [47:0] ld_data = 48'h0;
  logic mov = 1'b0;
  logic [1:0] mov_idx = 2'h0;
  logic [31:0] st_rdata, mov_data;
  logic mov_valid;
  int fail_count = 0;
  int checks_done = 0;
  logic [31:0] sgn_exp [2] = '{32'h0000_ffff, 32'hffff_ffff};

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  mac_issue_model i_pipe (
    .clk_i(clk_i), .op_valid_o(op_valid), .op_sub_o(op_sub), .op_word_o(op_word),
    .op_acc_o(op_acc), .op_a_o(op_a), .op_b_o(op_b)
  );

  mac_mode_status i_dut (
    .clk_i(clk_i), .reset_i(reset_i), .op_valid_i(op_valid), .op_sub_i(op_sub),
    .op_word_i(op_word), .op_acc_i(op_acc), .op_a_i(op_a), .op_b_i(op_b),
    .status_wr_i(st_wr), .status_wdata_i(st_wdata), .acc_load_i(ld),
    .acc_load_idx_i(ld_idx), .acc_load_data_i(ld_data), .move_i(mov),
    .move_idx_i(mov_idx), .status_rdata_o(st_rdata), .move_data_o(mov_data),
    .move_valid_o(mov_valid)
  );

  // --------------------------------------------------------------------
  // Access tasks
  // --------------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [31:0] d);
    @(posedge clk_i);
    st_wr <= 1'b1;
    st_wdata <= d;
    @(posedge clk_i);
    st_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic load(input logic [1:0] idx, input logic [47:0] d);
    @(posedge clk_i);
    ld <= 1'b1;
    ld_idx <= idx;
    ld_data <= d;
    @(posedge clk_i);
    ld <= 1'b0;
    ld_data <= ~d;
    #1;
  endtask : load

  task automatic op(input logic sub, input logic word, input logic [1:0] acc,
      input logic [31:0] a, input logic [31:0] b);
    i_pipe.issue(sub, word, acc, a, b);
  endtask : op

  task automatic st(input logic [31:0] exp);
    chk("status", exp, st_rdata);
  endtask : st

  // The pulse is checked in its own cycle and again one cycle later.
  task automatic mv(input logic [1:0] idx, input logic [31:0] exp);
    @(posedge clk_i);
    mov <= 1'b1;
    mov_idx <= idx;
    @(posedge clk_i);
    mov <= 1'b0;
    #1;
    chk("move valid", 32'h1, {31'h0, mov_valid});
    chk("move data", exp, mov_data);
    @(posedge clk_i);
    #1;
    chk("move valid end", 32'h0, {31'h0, mov_valid});
  endtask : mv

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  // --------------------------------------------------------------------
  // Watchdog
  // --------------------------------------------------------------------
  // The tests need about 140 cycles; four thousand leaves ample margin.
  initial begin
    #100000;
    fail_count++;
    wrap_up();
  end

  // --------------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    #1;
    st(32'h0);
    wr(32'h0000_0ff2);
    st(32'h0000_00f2);
    wr(32'h0);
    st(32'h0);
    // Signed integer, saturation off: the sum wraps.
    load(2'h0, 48'h7fff_ffff_ffff);
    op(1'b0, 1'b0, 2'h0, 32'h1, 32'h1);
    st(32'h0000_0102);
    mv(2'h0, 32'h0);
    op(1'b0, 1'b0, 2'h1, 32'h1, 32'h1);
    st(32'h0000_0100);
    op(1'b0, 1'b0, 2'h0, 32'h0, 32'h0);
    st(32'h0000_0102);
    load(2'h0, 48'h0);
    chk("flags", 32'h0, {28'h0, st_rdata[11:8]});
    // Signed saturation and hold.
    wr(32'h80);
    load(2'h2, 48'h7fff_ffff_ffff);
    op(1'b0, 1'b0, 2'h2, 32'h1, 32'h1);
    st(32'h0000_0482);
    mv(2'h2, 32'h7fff_ffff);
    op(1'b1, 1'b0, 2'h2, 32'h1, 32'h1);
    mv(2'h2, 32'h7fff_ffff);
    st(32'h0000_0482);
    load(2'h3, 48'h8000_0000_0000);
    op(1'b1, 1'b0, 2'h3, 32'h1, 32'h1);
    mv(2'h3, 32'h8000_0000);
    load(2'h2, 48'h0);
    op(1'b0, 1'b0, 2'h2, 32'h2, 32'h3);
    mv(2'h2, 32'h6);
    st(32'h0000_0880);
    wr(32'h80);
    st(32'h0000_0080);
    op(1'b0, 1'b0, 2'h3, 32'h1, 32'h1);
    mv(2'h3, 32'h8000_0001);
    // Unsigned saturation.
    wr(32'hc0);
    load(2'h1, 48'hffff_ffff_ffff);
    op(1'b0, 1'b0, 2'h1, 32'h1, 32'h1);
    mv(2'h1, 32'hffff_ffff);
    load(2'h1, 48'h0);
    op(1'b1, 1'b0, 2'h1, 32'h1, 32'h1);
    mv(2'h1, 32'h0);
    st(32'h0000_02c2);
    // Unsigned then signed word operands.
    for (int i = 0; i < 2; i++) begin
      wr((i == 0) ? 32'h40 : 32'h00);
      load(2'h0, 48'h0);
      op(1'b0, 1'b1, 2'h0, 32'h0000_ffff, 32'h0000_0001);
      mv(2'h0, sgn_exp[i]);
    end
    // Fractional against integer operands.
    wr(32'h20);
    load(2'h0, 48'h0);
    op(1'b0, 1'b1, 2'h0, 32'h4000, 32'h4000);
    mv(2'h0, 32'h2000_0000);
    wr(32'h0);
    load(2'h0, 48'h0);
    op(1'b0, 1'b1, 2'h0, 32'h4000, 32'h4000);
    mv(2'h0, 32'h1000_0000);
    wr(32'h20);
    op(1'b0, 1'b1, 2'h1, 32'h8000, 32'h8000);
    st(32'h0000_0222);
    // Move formatting and rounding.
    load(2'h0, 48'h0012_3456_7880);
    mv(2'h0, 32'h1234_5678);
    wr(32'h30);
    mv(2'h0, 32'h1234_5678);
    load(2'h0, 48'h0012_3456_7980);
    mv(2'h0, 32'h1234_567a);
    wr(32'h60);
    mv(2'h0, 32'h0000_1234);
    wr(32'h0);
    mv(2'h0, 32'h3456_7980);
    wrap_up();
  end
endmodule : tb_top
